// ### hw/mmx_pkg.sv
// Package for the move and multiply execute block.
// Assumes one core clock; an instruction cycle is four core clocks (four phases).
package mmx_pkg;
    // ------------------------------------------------------------------
    // Opcode fields (top bits of the 16-bit program word)
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_LOAD_LIT  = 8'h0e;  // 0000 1110 kkkk kkkk
    localparam logic [7:0] OP_MUL_LIT   = 8'h0d;  // 0000 1101 kkkk kkkk
    localparam logic [6:0] OP_STORE_W   = 7'h37;  // 0110 111a ffff ffff
    localparam logic [6:0] OP_MUL_FILE  = 7'h01;  // 0000 001a ffff ffff
    // ------------------------------------------------------------------
    // Addressing constants
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_LIMIT    = 8'h5f;  // Indexed offset applies at or below
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;  // Access bank low/high split
    localparam logic [3:0] ACCESS_HIGH  = 4'hf;   // Bank of upper access half
    localparam logic [3:0] ACCESS_LOW   = 4'h0;   // Bank of lower access half
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  W_RST       = 8'h00;
    localparam logic [15:0] PROD_RST    = 16'h0000;
    // ------------------------------------------------------------------
    // Phase machine, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_DECODE  = 4'b0001,
        PH_READ    = 4'b0010,
        PH_PROCESS = 4'b0100,
        PH_WRITE   = 4'b1000
    } mmx_phase_t;
    typedef enum logic [4:0] {
        OPK_NONE   = 5'b00001,
        OPK_LOADL  = 5'b00010,
        OPK_STORE  = 5'b00100,
        OPK_MULL   = 5'b01000,
        OPK_MULF   = 5'b10000
    } mmx_opk_t;
endpackage : mmx_pkg

// ### hw/mmx_exec.sv
// Execute logic for load literal, store working, and the two multiplies.
// Assumes the fetch unit holds i_instr stable for a whole instruction cycle
// and the data memory answers a read within the same phase in which the address is shown.
// Operation
// [RULE1] Opcode 0000 1110 with a literal loads the literal into W, flags untouched.
// [RULE2] Opcode 0110 111a with a file address writes W to that data byte, flags untouched.
// [RULE3] The 8-bit file address reaches any byte of the selected 256-byte bank.
// [RULE4] Access bit 0 selects the access bank; 1 takes the bank from the bank select reg.
// [RULE5] Access bit 0 with extended set on uses indexed literal offset for f <= 5Fh.
// [RULE6] Opcode 0000 1101 multiplies W by the literal, unsigned, W unchanged.
// [RULE7] Each multiply writes the 16-bit product, high byte and low byte to the pair.
// [RULE8] Opcode 0000 001a multiplies W by the file byte, unsigned, operands unchanged.
// [RULE9] Neither multiply alters any status flag.
// [RULE10] A zero product does not set the zero flag.
// [RULE11] Each instruction is one word, one cycle: decode, read, process, write.
module mmx_exec (
    input  wire logic        i_mclk,         // Core clock
    input  wire logic        i_srst,         // Sync reset, active high
    input  wire logic [15:0] i_instr,        // Program word for this cycle
    input  wire logic [3:0]  i_bank_select,  // Bank select register value
    input  wire logic        i_ext_set,      // Extended instruction set enabled
    input  wire logic [11:0] i_index_base,   // Index pointer for literal offset mode
    input  wire logic [7:0]  i_rd_data,      // Data memory read data
    output logic      [11:0] o_addr,         // Data memory address
    output logic             o_rd,           // Data memory read strobe
    output logic             o_wr,           // Data memory write strobe
    output logic      [7:0]  o_wr_data,      // Data memory write data
    output logic      [7:0]  o_working,      // Working register
    output logic      [7:0]  o_product_high_byte, // Product high byte
    output logic      [7:0]  o_product_low_byte,  // Product low byte
    output logic             o_flags_we,     // Status flag write, never set here
    output logic             o_cycle_done    // Pulse at end of instruction cycle
);
    // ------------------------------------------------------------------
    // Decode function
    // ------------------------------------------------------------------
    function automatic mmx_pkg::mmx_opk_t decode_op(input logic [15:0] w);
        mmx_pkg::mmx_opk_t k;
        k = mmx_pkg::OPK_NONE;
        if (w[15:8] == mmx_pkg::OP_LOAD_LIT)
            k = mmx_pkg::OPK_LOADL;                            // [RULE1]
        else if (w[15:8] == mmx_pkg::OP_MUL_LIT)
            k = mmx_pkg::OPK_MULL;                             // [RULE6]
        else if (w[15:9] == mmx_pkg::OP_STORE_W)
            k = mmx_pkg::OPK_STORE;                            // [RULE2]
        else if (w[15:9] == mmx_pkg::OP_MUL_FILE)
            k = mmx_pkg::OPK_MULF;                             // [RULE8]
        return k;
    endfunction : decode_op

    // File-operand opcodes share the bank, access and indexed address forming
    function automatic logic is_file_op(input logic [15:0] w);
        return (decode_op(w) == mmx_pkg::OPK_STORE) || (decode_op(w) == mmx_pkg::OPK_MULF);
    endfunction : is_file_op

    // Address forming function: bank or access or indexed
    function automatic logic [11:0] file_addr(input logic a, input logic [7:0] f,
                                               input logic [3:0] bank_select_register, input logic ext,
                                               input logic [11:0] base);
        logic [11:0] r;
        r = 12'h000;
        if (a)
            r = {bank_select_register, f};                                      // [RULE3] [RULE4]
        else if (ext && (f <= mmx_pkg::IDX_LIMIT))
            r = 12'(base + {4'h0, f});                         // [RULE5]
        else if (f < mmx_pkg::ACCESS_SPLIT)
            r = {mmx_pkg::ACCESS_LOW, f};                      // [RULE4]
        else
            r = {mmx_pkg::ACCESS_HIGH, f};
        return r;
    endfunction : file_addr

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Phase and decoded kind, then the datapath and memory-side flops
    mmx_pkg::mmx_phase_t phase_reg, phase_next;
    mmx_pkg::mmx_opk_t   op_reg,    op_next;
    logic [7:0]  opnd_reg,  opnd_next;
    logic [15:0] res_reg,   res_next;
    logic [7:0]  w_reg,     w_next;
    logic [15:0] prod_reg,  prod_next;
    logic [11:0] addr_reg,  addr_next;
    logic        rd_reg,    rd_next;
    logic        wr_reg,    wr_next;
    logic [7:0]  wd_reg,    wd_next;
    logic        done_reg,  done_next;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Next-state logic: the four phases of one instruction cycle
    always_comb
    begin
        phase_next = phase_reg;
        op_next    = op_reg;
        opnd_next  = opnd_reg;
        res_next   = res_reg;
        w_next     = w_reg;
        prod_next  = prod_reg;
        addr_next  = addr_reg;
        rd_next    = 1'b0;
        wr_next    = 1'b0;
        wd_next    = wd_reg;
        done_next  = 1'b0;
        case (phase_reg)
            mmx_pkg::PH_DECODE:
            begin
                // The address is formed for every word; only file opcodes use it
                op_next    = decode_op(i_instr);               // [RULE11]
                addr_next  = file_addr(i_instr[8], i_instr[7:0], i_bank_select,
                                       i_ext_set, i_index_base);
                rd_next    = (decode_op(i_instr) == mmx_pkg::OPK_MULF);
                phase_next = mmx_pkg::PH_READ;
            end
            mmx_pkg::PH_READ:
            begin
                // Literal comes from the word; file byte from memory
                if (op_reg == mmx_pkg::OPK_MULF)
                    opnd_next = i_rd_data;                     // [RULE8]
                else
                    opnd_next = i_instr[7:0];
                phase_next = mmx_pkg::PH_PROCESS;
            end
            mmx_pkg::PH_PROCESS:
            begin
                // Unsigned 8x8 cannot overflow 16 bits, so no carry is formed
                res_next   = {8'h00, w_reg} * {8'h00, opnd_reg}; // [RULE6] [RULE8] [RULE9]
                phase_next = mmx_pkg::PH_WRITE;
            end
            mmx_pkg::PH_WRITE:
            begin
                // Results land together at the end of the cycle, one consistent update
                case (op_reg)
                    mmx_pkg::OPK_LOADL: w_next = opnd_reg;     // [RULE1]
                    mmx_pkg::OPK_STORE:
                    begin
                        wr_next = 1'b1;                        // [RULE2]
                        wd_next = w_reg;
                    end
                    mmx_pkg::OPK_MULL,
                    mmx_pkg::OPK_MULF: prod_next = res_reg;    // [RULE7] [RULE10]
                    default: w_next = w_reg;
                endcase
                done_next  = 1'b1;
                phase_next = mmx_pkg::PH_DECODE;
            end
            default: phase_next = mmx_pkg::PH_DECODE;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Plain register stage; every decision lives in the block above
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            phase_reg <= mmx_pkg::PH_DECODE;
            op_reg    <= mmx_pkg::OPK_NONE;
            opnd_reg  <= 8'h00;
            res_reg   <= mmx_pkg::PROD_RST;
            w_reg     <= mmx_pkg::W_RST;
            prod_reg  <= mmx_pkg::PROD_RST;
            addr_reg  <= 12'h000;
            rd_reg    <= 1'b0;
            wr_reg    <= 1'b0;
            wd_reg    <= 8'h00;
            done_reg  <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            op_reg    <= op_next;
            opnd_reg  <= opnd_next;
            res_reg   <= res_next;
            w_reg     <= w_next;
            prod_reg  <= prod_next;
            addr_reg  <= addr_next;
            rd_reg    <= rd_next;
            wr_reg    <= wr_next;
            wd_reg    <= wd_next;
            done_reg  <= done_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Outputs straight from flops; flag write is a constant-low flop
    logic flags_we_reg;
    always_ff @(posedge i_mclk)
    begin
        flags_we_reg <= 1'b0;                                  // [RULE9] [RULE10]
    end
    assign o_addr              = addr_reg;
    assign o_rd                = rd_reg;
    assign o_wr                = wr_reg;
    assign o_wr_data           = wd_reg;
    assign o_working           = w_reg;
    assign o_product_high_byte = prod_reg[15:8];
    assign o_product_low_byte  = prod_reg[7:0];
    assign o_flags_we          = flags_we_reg;
    assign o_cycle_done        = done_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_mull_decoded;
        phase_reg == mmx_pkg::PH_DECODE && i_instr[15:8] == mmx_pkg::OP_MUL_LIT;
    endsequence
    // Operands are taken back from the decode edge: the next word is on i_instr by then
    sequence s_prod_written;
        ##4 prod_reg == ({8'h00, $past(w_reg, 4)} * {8'h00, $past(i_instr[7:0], 4)});
    endsequence
    sequence s_mulf_decoded;
        phase_reg == mmx_pkg::PH_DECODE && i_instr[15:9] == mmx_pkg::OP_MUL_FILE;
    endsequence
    // The file byte is sampled in the read phase, one edge after decode
    sequence s_mulf_written;
        ##4 prod_reg == ({8'h00, $past(w_reg, 4)} * {8'h00, $past(i_rd_data, 3)});
    endsequence
    // Decode, read, process, write, then decode again
    sequence s_phase_walk;
        phase_reg == mmx_pkg::PH_READ ##1 phase_reg == mmx_pkg::PH_PROCESS
        ##1 phase_reg == mmx_pkg::PH_WRITE ##1 phase_reg == mmx_pkg::PH_DECODE;
    endsequence

    // Multiplies, literal load, store, addressing, flags and cycle length
    a_mull_product: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE6]
        s_mull_decoded |-> s_prod_written)
        else $error("literal multiply product wrong");
    a_mulf_product: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE8]
        s_mulf_decoded |-> s_mulf_written)
        else $error("file multiply product wrong");
    a_mull_keepw: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE6]
        s_mull_decoded |-> ##4 (w_reg == $past(w_reg, 4) && !o_wr))
        else $error("literal multiply altered W");
    a_loadl_value: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE1]
        (phase_reg == mmx_pkg::PH_DECODE && i_instr[15:8] == mmx_pkg::OP_LOAD_LIT)
        |-> ##4 w_reg == $past(i_instr[7:0], 4))
        else $error("literal load wrong");
    a_store_write: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE2]
        (phase_reg == mmx_pkg::PH_DECODE && i_instr[15:9] == mmx_pkg::OP_STORE_W)
        |-> ##4 (o_wr && o_wr_data == $past(w_reg, 4)))
        else $error("store write missing");
    a_bank_addr: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE4]
        (phase_reg == mmx_pkg::PH_DECODE && i_instr[8] && is_file_op(i_instr))
        |=> o_addr == {$past(i_bank_select), $past(i_instr[7:0])})
        else $error("banked address wrong");
    a_index_addr: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE5]
        (phase_reg == mmx_pkg::PH_DECODE && !i_instr[8] && i_ext_set
         && i_instr[7:0] <= mmx_pkg::IDX_LIMIT)
        |=> o_addr == 12'($past(i_index_base) + {4'h0, $past(i_instr[7:0])}))
        else $error("indexed address wrong");
    a_mulf_keepw: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE8]
        (phase_reg == mmx_pkg::PH_DECODE && i_instr[15:9] == mmx_pkg::OP_MUL_FILE)
        |-> ##4 (w_reg == $past(w_reg, 4) && !o_wr))
        else $error("file multiply altered operand");
    a_no_flags: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE9]
        !o_flags_we)
        else $error("status flags written");
    a_cycle_four: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE11]
        o_cycle_done |-> ##1 !o_cycle_done [*3] ##1 o_cycle_done)
        else $error("instruction cycle not four phases");
    a_prod_only_mul: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE7]
        (prod_reg != $past(prod_reg)) |-> $past(op_reg == mmx_pkg::OPK_MULL
                                              || op_reg == mmx_pkg::OPK_MULF))
        else $error("product changed without multiply");

    // Memory strobes belong to their own opcode and phase only
    a_rd_mulf_only: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE8]
        o_rd |-> (op_reg == mmx_pkg::OPK_MULF && phase_reg == mmx_pkg::PH_READ))
        else $error("read strobe outside file multiply");
    a_wr_store_only: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE2]
        o_wr |-> $past(op_reg == mmx_pkg::OPK_STORE && phase_reg == mmx_pkg::PH_WRITE))
        else $error("write strobe outside store");

    // Access bank halves when no indexed offset applies
    a_access_low: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE4]
        (phase_reg == mmx_pkg::PH_DECODE && !i_instr[8] && !i_ext_set
         && i_instr[7:0] < mmx_pkg::ACCESS_SPLIT && is_file_op(i_instr))
        |=> o_addr == {mmx_pkg::ACCESS_LOW, $past(i_instr[7:0])})
        else $error("lower access address wrong");
    a_access_high: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE4]
        (phase_reg == mmx_pkg::PH_DECODE && !i_instr[8]
         && i_instr[7:0] >= mmx_pkg::ACCESS_SPLIT && is_file_op(i_instr))
        |=> o_addr == {mmx_pkg::ACCESS_HIGH, $past(i_instr[7:0])})
        else $error("upper access address wrong");

    // W moves only on a literal load; both multiplies leave it alone
    a_w_only_load: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE6]
        (w_reg != $past(w_reg)) |-> $past(op_reg == mmx_pkg::OPK_LOADL
                                          && phase_reg == mmx_pkg::PH_WRITE))
        else $error("working register changed outside load");

    // The cycle is exactly four phases, with done raised out of the write phase
    a_phase_order: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE11]
        phase_reg == mmx_pkg::PH_DECODE |=> s_phase_walk)
        else $error("phase order broken");
    a_done_write: assert property (@(posedge i_mclk) disable iff (i_srst) // [RULE11]
        o_cycle_done |-> $past(phase_reg == mmx_pkg::PH_WRITE))
        else $error("done raised outside write phase");
endmodule : mmx_exec

// ### verif/mmx_exec_tb.sv
// Self-checking bench for the move and multiply execute block.
// Assumes one instruction per four core clocks, presented at the falling edge.
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------------
    logic        i_mclk        = 1'b0;
    logic        i_srst        = 1'b1;
    logic [15:0] i_instr       = 16'h0000;
    logic [3:0]  i_bank_select = 4'h0;
    logic        i_ext_set     = 1'b0;
    logic [11:0] i_index_base  = 12'h000;
    logic [7:0]  i_rd_data     = 8'h00;
    logic [11:0] o_addr;
    logic        o_rd;
    logic        o_wr;
    logic [7:0]  o_wr_data;
    logic [7:0]  o_working;
    logic [7:0]  o_product_high_byte;
    logic [7:0]  o_product_low_byte;
    logic        o_flags_we;
    logic        o_cycle_done;
    int          err_total     = 0;
    int          compares      = 0;
    int          rd_cnt;
    int          flag_cnt      = 0;
    logic        done_p;
    logic        wr_p;
    logic [7:0]  wdat_p;
    logic [7:0]  w_p;
    logic [15:0] prod_p;
    logic [11:0] addr_s;
    logic        done_c;
    logic        wr_c;
    logic [7:0]  wdat_c;
    logic [7:0]  w_c;
    logic [15:0] prod_c;

    // 10 MHz core clock
    always #50 i_mclk = ~i_mclk;

    mmx_exec uut (.i_mclk(i_mclk), .i_srst(i_srst), .i_instr(i_instr),
        .i_bank_select(i_bank_select), .i_ext_set(i_ext_set), .i_index_base(i_index_base),
        .i_rd_data(i_rd_data), .o_addr(o_addr), .o_rd(o_rd), .o_wr(o_wr),
        .o_wr_data(o_wr_data), .o_working(o_working),
        .o_product_high_byte(o_product_high_byte), .o_product_low_byte(o_product_low_byte),
        .o_flags_we(o_flags_we), .o_cycle_done(o_cycle_done));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One instruction cycle; results of the previous one move to the _p copies
    task automatic issue(input logic [15:0] instr, input logic [7:0] rd);
        done_p    = done_c;
        wr_p      = wr_c;
        wdat_p    = wdat_c;
        w_p       = w_c;
        prod_p    = prod_c;
        i_instr   = instr;
        i_rd_data = rd;
        rd_cnt    = 0;
        for (int n = 1; n <= 4; n++)
        begin
            @(negedge i_mclk);
            if (n == 2)
                addr_s = o_addr;
            if (n == 4)
            begin
                // Done and the write strobe stand one cycle only, so take them here
                done_c = o_cycle_done;
                wr_c   = o_wr;
                wdat_c = o_wr_data;
                w_c    = o_working;
                prod_c = {o_product_high_byte, o_product_low_byte};
            end
            rd_cnt   += int'(o_rd);
            flag_cnt += int'(o_flags_we);
        end
    endtask : issue

    // Judges the instruction issued before the latest one
    task automatic expect_prev(input logic [7:0] w, input logic [15:0] prod, input logic wr);
        check({15'h0000, done_p}, 16'h0001);
        check({8'h00, w_p}, {8'h00, w});
        check(prod_p, prod);
        check({15'h0000, wr_p}, {15'h0000, wr});
    endtask : expect_prev

    task automatic complete_run;
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic sc_load_and_mul_literal;
        issue(16'h0e5a, 8'h00);
        issue(16'h0ee2, 8'h00);
        expect_prev(8'h5a, 16'h0000, 1'b0);
        issue(16'h0dc4, 8'h00);
        issue(16'h0d00, 8'h00);
        expect_prev(8'he2, 16'had08, 1'b0);
        issue(16'h0000, 8'h00);
        expect_prev(8'he2, 16'h0000, 1'b0);
    endtask : sc_load_and_mul_literal

    // Bank from the select register, including the last byte of the top bank
    task automatic sc_mul_file;
        issue(16'h0ec4, 8'h00);
        i_bank_select = 4'h5;
        issue(16'h033a, 8'hb5);
        check(addr_s, 16'h053a);
        check(16'(rd_cnt), 16'h0001);
        i_bank_select = 4'hf;
        issue(16'h03ff, 8'h02);
        expect_prev(8'hc4, 16'h8a94, 1'b0);
        check(addr_s, 16'h0fff);
        issue(16'h0000, 8'h00);
        expect_prev(8'hc4, 16'h0188, 1'b0);
    endtask : sc_mul_file

    // Access bank split and indexed offset on both sides of the limit
    task automatic sc_store;
        issue(16'h6e60, 8'h00);
        check(addr_s, 16'h0f60);
        check(16'(rd_cnt), 16'h0000);
        issue(16'h6e5f, 8'h00);
        check({15'h0000, wr_p}, 16'h0001);
        check({8'h00, wdat_p}, 16'h00c4);
        check(addr_s, 16'h005f);
        i_ext_set    = 1'b1;
        i_index_base = 12'h100;
        issue(16'h6e5f, 8'h00);
        check(addr_s, 16'h015f);
        issue(16'h6e60, 8'h00);
        check(addr_s, 16'h0f60);
        i_ext_set = 1'b0;
        issue(16'h0000, 8'h00);
        expect_prev(8'hc4, 16'h0188, 1'b1);
    endtask : sc_store

    // Back-to-back cycles, each using the working value left by the one before
    task automatic sc_back_to_back;
        issue(16'h0eff, 8'h00);
        issue(16'h0dff, 8'h00);
        issue(16'h0d01, 8'h00);
        expect_prev(8'hff, 16'hfe01, 1'b0);
        issue(16'hffff, 8'h00);
        expect_prev(8'hff, 16'h00ff, 1'b0);
        issue(16'h0000, 8'h00);
        expect_prev(8'hff, 16'h00ff, 1'b0);
    endtask : sc_back_to_back

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (20) @(negedge i_mclk);
        check({o_working, o_product_low_byte}, 16'h0000);
        check({8'h00, o_product_high_byte}, 16'h0000);
        i_srst = 1'b0;
        sc_load_and_mul_literal();
        sc_mul_file();
        sc_store();
        sc_back_to_back();
        check(16'(flag_cnt), 16'h0000);
        complete_run();
    end
endmodule : tb
